//--- design/adcsf_top.sv
// Converter status flags, result store, registers and interrupt
//
// Operation
// - A finished conversion sets that channel's done flag.
// - Reading a channel result clears that done flag; a last result read clears every done flag.
// - A status read clears channel overrun flags, except one set by an end of conversion in the same cycle.
// - Finish while own done and result-ready active sets general overrun, whatever read.
// - Disabling another channel during a finish still raises general overrun.
// - In that case the finishing channel's overrun flag rises only if its done flag is still set.
// - A channel disabled during its conversion never raises its done flag.
// - Reading channel z's result clears only z's done flag.
// - Sleep set while idle takes effect after the next conversion sequence ends.
// - Only a last result read clears result-ready; channel reads leave it.
// - A finish while result-ready is active sets general overrun.
// - Each finish stores the channel and last results and raises result-ready.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adcsf_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [adcsf_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [adcsf_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sampled analogue values, one word per channel
  input wire adcsf_pkg::adcsf_ain_t ain,
  // Status outputs
  output logic irq,
  output logic asleep
);
  import adcsf_pkg::*;

  typedef struct packed {
    adcsf_ain_t ain1;
    adcsf_ain_t ain2;
    logic [NCH-1:0] cher;
    logic sleep_en;
    logic asleep;
    logic [NCH-1:0] done;
    logic [NCH-1:0] ovr;
    logic result_ready_flag;
    logic general_overrun_flag;
    logic [NCH-1:0][DW-1:0] res;
    logic [DW-1:0] last;
    logic [CHW-1:0] last_ch;
    logic [NEV-1:0] imr;
    logic [NEV-1:0] isr;
  } adcsf_st_t;

  adcsf_st_t s_q, s_d;
  adcsf_req_t req;
  adcsf_rsp_t rsp;
  adcsf_cev_t cev;
  logic start_wr;
  logic [NCH-1:0] en_now, dis_now;
  logic rd_sr, rd_last_result_reg, rd_cdr;
  logic [CHW-1:0] rd_idx;
  logic eoc_ok;
  logic [NCH-1:0] done_set, done_clr, done_keep, ovr_set;
  logic general_overrun_flag_set;
  logic [NEV-1:0] ev;

  function automatic logic cdr_hit(input logic [AW-1:0] a);
    cdr_hit = (a >= OFS_CDR0) && (a < AW'(OFS_CDR0 + 4 * NCH)) && (a[1:0] == 2'b00);
  endfunction : cdr_hit

  function automatic logic [NCH-1:0] onehot(input logic [CHW-1:0] c);
    onehot = NCH'(1) << c;
  endfunction : onehot

  function automatic logic wr_at(input adcsf_req_t r, input logic [AW-1:0] a);
    wr_at = r.wr && (r.waddr == a) && r.wstrb[0];
  endfunction : wr_at

  adcsf_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req),
    .rsp(rsp)
  );

  adcsf_conv u_conv (
    .aclk(aclk),
    .aresetn(aresetn),
    .chen(s_q.cher),
    .start(start_wr),
    .ain(s_q.ain2),
    .cev(cev)
  );

  // Register decode
  always_comb begin
    start_wr = wr_at(req, OFS_CR) && req.wdata[CR_START];
    en_now = wr_at(req, OFS_CHER) ? req.wdata[NCH-1:0] : '0;
    dis_now = wr_at(req, OFS_CHDR) ? req.wdata[NCH-1:0] : '0;
    rd_sr = req.rd && (req.raddr == OFS_SR);
    rd_last_result_reg = req.rd && (req.raddr == OFS_LAST_RESULT_REG);
    rd_cdr = req.rd && cdr_hit(req.raddr);
    rd_idx = CHW'((req.raddr - OFS_CDR0) >> 2);
  end

  // Flag next values
  always_comb begin
    // A disable arriving with the finish still counts as disabled
    eoc_ok = cev.eoc && s_q.cher[cev.ch] && !dis_now[cev.ch];
    done_set = eoc_ok ? onehot(cev.ch) : '0;
    done_clr = (rd_cdr ? onehot(rd_idx) : '0) | {NCH{rd_last_result_reg}};
    done_keep = s_q.done & ~done_clr;
    ovr_set = done_set & s_q.done;
    // Only result-ready matters; which channel or read is irrelevant
    general_overrun_flag_set = eoc_ok && s_q.result_ready_flag;
    ev = '0;
    ev[EV_EOC] = eoc_ok;
    ev[EV_OVR] = |ovr_set;
    ev[EV_GENERAL_OVERRUN_FLAG] = general_overrun_flag_set;
    ev[EV_SEQ] = cev.seq_end;
  end

  always_comb begin
    s_d = s_q;
    s_d.ain1 = ain;
    s_d.ain2 = s_q.ain1;
    s_d.cher = (s_q.cher | en_now) & ~dis_now;
    if (wr_at(req, OFS_MR)) begin
      s_d.sleep_en = req.wdata[MR_SLEEP];
    end
    if (wr_at(req, OFS_IMR)) begin
      s_d.imr = req.wdata[NEV-1:0];
    end
    s_d.isr = s_q.isr & ~(wr_at(req, OFS_ISR) ? req.wdata[NEV-1:0] : '0);
    s_d.isr = s_d.isr | ev;
    s_d.done = done_keep | done_set;
    s_d.ovr = (s_q.ovr & ~{NCH{rd_sr}}) | ovr_set;
    s_d.general_overrun_flag = (s_q.general_overrun_flag && !rd_sr) || general_overrun_flag_set;
    s_d.result_ready_flag = (s_q.result_ready_flag && !rd_last_result_reg) || eoc_ok;
    if (eoc_ok) begin
      s_d.res[cev.ch] = cev.data;
      s_d.last = cev.data;
      s_d.last_ch = cev.ch;
    end
    // Sleep never cuts a conversion short; it waits for the sequence end
    if (start_wr || !s_q.sleep_en) begin
      s_d.asleep = 1'b0;
    end else if (cev.seq_end) begin
      s_d.asleep = 1'b1;
    end
  end

  // Read data and decode errors
  always_comb begin
    rsp.rdata = '0;
    rsp.rerr = 1'b0;
    rsp.werr = !(wr_at(req, OFS_CR) || wr_at(req, OFS_MR) || wr_at(req, OFS_CHER)
      || wr_at(req, OFS_CHDR) || wr_at(req, OFS_IMR) || wr_at(req, OFS_ISR))
      && (req.wstrb[0] || req.waddr != OFS_CR);
    if (cdr_hit(req.raddr)) begin
      rsp.rdata[DW-1:0] = s_q.res[rd_idx];
    end else begin
      unique case (req.raddr)
        OFS_MR: rsp.rdata[MR_SLEEP] = s_q.sleep_en;
        OFS_CHSR: rsp.rdata[NCH-1:0] = s_q.cher;
        OFS_SR: begin
          rsp.rdata[NCH-1:0] = s_q.done;
          rsp.rdata[SR_OVR_LSB +: NCH] = s_q.ovr;
          rsp.rdata[SR_RESULT_READY_FLAG] = s_q.result_ready_flag;
          rsp.rdata[SR_GENERAL_OVERRUN_FLAG] = s_q.general_overrun_flag;
          rsp.rdata[SR_ASLEEP] = s_q.asleep;
          rsp.rdata[SR_BUSY] = cev.busy;
        end
        OFS_LAST_RESULT_REG: begin
          rsp.rdata[DW-1:0] = s_q.last;
          rsp.rdata[LAST_RESULT_REG_CH_LSB +: CHW] = s_q.last_ch;
        end
        OFS_IMR: rsp.rdata[NEV-1:0] = s_q.imr;
        OFS_ISR: rsp.rdata[NEV-1:0] = s_q.isr;
        OFS_CR, OFS_CHER, OFS_CHDR: rsp.rdata = '0;
        default: rsp.rerr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{cher: CHER_RST, imr: IMR_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign irq = |(s_q.isr & s_q.imr);
  assign asleep = s_q.asleep;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_done_set;
    logic [CHW-1:0] c;
    (eoc_ok, c = cev.ch) |=> s_q.done[c];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_last_result_reg_clr;
    rd_last_result_reg && !eoc_ok |=> s_q.done == '0;
  endproperty
  a_last_result_reg_clr: assert property (p_last_result_reg_clr) else $error("last read left done");

  property p_ovr_clr;
    rd_sr |=> s_q.ovr == $past(ovr_set);
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not reset");

  property p_general_overrun_flag;
    eoc_ok && s_q.result_ready_flag && (rd_cdr || !rd_sr) |=> s_q.general_overrun_flag;
  endproperty
  a_general_overrun_flag: assert property (p_general_overrun_flag) else $error("general overrun missed");

  property p_general_overrun_flag_dis;
    eoc_ok && s_q.result_ready_flag && (dis_now != '0) |=> s_q.general_overrun_flag ##1 1'b1;
  endproperty
  a_general_overrun_flag_dis: assert property (p_general_overrun_flag_dis) else $error("overrun lost on disable");

  property p_ovr_dis;
    logic [CHW-1:0] c;
    (eoc_ok && s_q.done[cev.ch], c = cev.ch) |=> s_q.ovr[c];
  endproperty
  a_ovr_dis: assert property (p_ovr_dis) else $error("channel overrun missed");

  property p_no_eoc;
    !eoc_ok |=> (s_q.done & ~$past(s_q.done)) == '0;
  endproperty
  a_no_eoc: assert property (p_no_eoc) else $error("done set without finish");

  property p_clr_z;
    rd_cdr && !eoc_ok && !rd_last_result_reg |=> s_q.done == $past(done_keep);
  endproperty
  a_clr_z: assert property (p_clr_z) else $error("wrong done cleared");

  property p_sleep;
    cev.seq_end && s_q.sleep_en && !start_wr |=> s_q.asleep;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_sleep_wait;
    !s_q.asleep && !cev.seq_end |=> !s_q.asleep;
  endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("sleep too early");

  property p_result_ready_flag_keep;
    s_q.result_ready_flag && !rd_last_result_reg |=> s_q.result_ready_flag [*2] or (##1 $past(rd_last_result_reg));
  endproperty
  a_result_ready_flag_keep: assert property (p_result_ready_flag_keep) else $error("ready cleared wrongly");

  property p_store;
    eoc_ok |=> s_q.result_ready_flag && s_q.last == $past(cev.data) && s_q.last_ch == $past(cev.ch);
  endproperty
  a_store: assert property (p_store) else $error("result not stored");

  property p_set_wins;
    eoc_ok && rd_last_result_reg |=> s_q.result_ready_flag && s_q.done != '0;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

  c_overrun: cover property (eoc_ok && s_q.result_ready_flag ##1 s_q.general_overrun_flag);
  c_sleep: cover property (cev.seq_end && s_q.sleep_en ##1 s_q.asleep);
  c_set_clr: cover property (eoc_ok && rd_cdr && rd_idx != cev.ch);
  c_irq: cover property (!irq ##1 irq);
endmodule : adcsf_top

//--- design/adcsf_pkg.sv
// Shared constants and types of the converter status-flag block
package adcsf_pkg;
  localparam int NCH = 8;
  localparam int DW = 10;
  localparam int CHW = 3;
  localparam int AW = 8;
  localparam int CLK_NS = 5;
  localparam int CONV_NS = 1000;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNTW = 8;
  localparam logic [AW-1:0] OFS_CR = 8'h00;
  localparam logic [AW-1:0] OFS_MR = 8'h04;
  localparam logic [AW-1:0] OFS_CHER = 8'h10;
  localparam logic [AW-1:0] OFS_CHDR = 8'h14;
  localparam logic [AW-1:0] OFS_CHSR = 8'h18;
  localparam logic [AW-1:0] OFS_SR = 8'h1c;
  localparam logic [AW-1:0] OFS_LAST_RESULT_REG = 8'h20;
  localparam logic [AW-1:0] OFS_IMR = 8'h24;
  localparam logic [AW-1:0] OFS_ISR = 8'h28;
  localparam logic [AW-1:0] OFS_CDR0 = 8'h30;
  localparam int CR_START = 0;
  localparam int MR_SLEEP = 0;
  localparam int SR_OVR_LSB = 8;
  localparam int SR_RESULT_READY_FLAG = 16;
  localparam int SR_GENERAL_OVERRUN_FLAG = 17;
  localparam int SR_ASLEEP = 18;
  localparam int SR_BUSY = 19;
  localparam int LAST_RESULT_REG_CH_LSB = 12;
  localparam int NEV = 4;
  localparam int EV_EOC = 0;
  localparam int EV_OVR = 1;
  localparam int EV_GENERAL_OVERRUN_FLAG = 2;
  localparam int EV_SEQ = 3;
  localparam logic [NCH-1:0] CHER_RST = 8'h00;
  localparam logic [NEV-1:0] IMR_RST = 4'h0;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ADCSF_IDLE = 2'b01,
    ADCSF_CONV = 2'b10
  } adcsf_cst_t;

  typedef logic [NCH-1:0][DW-1:0] adcsf_ain_t;

  typedef struct packed {
    logic wr;
    logic [AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic rd;
    logic [AW-1:0] raddr;
  } adcsf_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic rerr;
    logic werr;
  } adcsf_rsp_t;

  typedef struct packed {
    logic eoc;
    logic [CHW-1:0] ch;
    logic [DW-1:0] data;
    logic seq_end;
    logic busy;
  } adcsf_cev_t;
endpackage : adcsf_pkg

//--- design/adcsf_axil.sv
// AXI4-Lite slave front end of the converter status-flag block
`timescale 1ns/1ps
module adcsf_axil (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [adcsf_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read
  input wire logic [adcsf_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output adcsf_pkg::adcsf_req_t req,
  input wire adcsf_pkg::adcsf_rsp_t rsp
);
  import adcsf_pkg::*;

  typedef struct packed {
    logic aw_v;
    logic [AW-1:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcsf_axs_t;

  adcsf_axs_t s_q, s_d;

  assign s_axi_awready = !s_q.aw_v;
  assign s_axi_wready = !s_q.w_v;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  always_comb begin
    s_d = s_q;
    req = '0;
    if (s_axi_awvalid && !s_q.aw_v) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_v) begin
      s_d.w_v = 1'b1;
      s_d.w_d = s_axi_wdata;
      s_d.w_s = s_axi_wstrb;
    end
    // Address and data are held until both are in, in either order
    if (s_q.aw_v && s_q.w_v && !s_q.bvalid) begin
      req.wr = 1'b1;
      req.waddr = s_q.aw_a;
      req.wdata = s_q.w_d;
      req.wstrb = s_q.w_s;
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = rsp.werr ? RESP_SLVERR : RESP_OK;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read side effects fire exactly once, at the address handshake
    if (s_axi_arvalid && !s_q.rvalid) begin
      req.rd = 1'b1;
      req.raddr = s_axi_araddr;
      s_d.rvalid = 1'b1;
      s_d.rdata = rsp.rdata;
      s_d.rresp = rsp.rerr ? RESP_SLVERR : RESP_OK;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : adcsf_axil

//--- design/adcsf_conv.sv
// Channel sequencer and conversion timer
`timescale 1ns/1ps
module adcsf_conv (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic [adcsf_pkg::NCH-1:0] chen,
  input wire logic start,
  input wire adcsf_pkg::adcsf_ain_t ain,
  // Conversion events
  output adcsf_pkg::adcsf_cev_t cev
);
  import adcsf_pkg::*;

  typedef struct packed {
    adcsf_cst_t st;
    logic [NCH-1:0] pend;
    logic [CHW-1:0] ch;
    logic [CNTW-1:0] cnt;
    logic eoc;
    logic [CHW-1:0] eoc_ch;
    logic [DW-1:0] data;
    logic seq_end;
  } adcsf_cvs_t;

  adcsf_cvs_t s_q, s_d;
  logic [NCH-1:0] rest;

  function automatic logic [CHW-1:0] first_ch(input logic [NCH-1:0] m);
    first_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_ch = CHW'(i);
      end
    end
  endfunction : first_ch

  always_comb begin
    s_d = s_q;
    s_d.eoc = 1'b0;
    s_d.seq_end = 1'b0;
    rest = s_q.pend & chen;
    rest[s_q.ch] = 1'b0;
    unique case (s_q.st)
      ADCSF_IDLE: begin
        if (start && |chen) begin
          s_d.st = ADCSF_CONV;
          s_d.pend = chen;
          s_d.ch = first_ch(chen);
          s_d.cnt = CNTW'(CONV_CYC - 1);
        end
      end
      ADCSF_CONV: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          // Channels one after another, lowest index first
          s_d.eoc = 1'b1;
          s_d.data = ain[s_q.ch];
          s_d.eoc_ch = s_q.ch;
          s_d.pend = rest;
          if (|rest) begin
            s_d.ch = first_ch(rest);
            s_d.cnt = CNTW'(CONV_CYC - 1);
          end else begin
            s_d.st = ADCSF_IDLE;
            s_d.seq_end = 1'b1;
          end
        end
      end
      default: begin
        s_d.st = ADCSF_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{st: ADCSF_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Channel of the finished conversion travels with its pulse
  always_comb begin
    cev.eoc = s_q.eoc;
    cev.ch = s_q.eoc ? s_q.eoc_ch : s_q.ch;
    cev.data = s_q.data;
    cev.seq_end = s_q.seq_end;
    cev.busy = (s_q.st == ADCSF_CONV);
  end
endmodule : adcsf_conv

//--- testbench/test_adcsf_top.sv
// Self-checking bench for the converter status-flag block
`timescale 1ns/1ps
module test_adcsf_top;
  import adcsf_pkg::*;
  logic aclk;
  logic aresetn;
  logic [AW-1:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [AW-1:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  adcsf_ain_t ain;
  logic irq;
  logic asleep;
  int n_mismatch;
  int samples_checked;
  int cyc;
  logic [31:0] v;
  logic [1:0] r;

  adcsf_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ain(ain), .irq(irq),
    .asleep(asleep)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Hang guard: whole run needs well under this many cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each released when taken
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, RESP_OK});
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] e;
    rd(a, d, e);
    chk({30'h0, e}, {30'h0, RESP_OK});
    chk(d, exp);
  endtask : rdc

  // Poll the sticky sequence-end bit; polling the interrupt status has no side effect
  task automatic wait_seq;
    logic [31:0] d;
    logic [1:0] e;
    do rd(OFS_ISR, d, e); while (!d[EV_SEQ]);
    wr(OFS_ISR, 32'h1 << EV_SEQ);
  endtask : wait_seq

  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : chk_irq

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    ain = '0;
    ain[0] = 10'h123;
    ain[1] = 10'h2a5;
    ain[2] = 10'h055;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped place
    rdc(OFS_CHSR, 32'h0);
    rdc(OFS_IMR, 32'h0);
    rdc(OFS_SR, 32'h0);
    rd(8'h2c, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk_irq(1'b0);
    // Channel 2 is dropped during the run and must stay silent
    wr(OFS_IMR, 32'hf);
    rdc(OFS_IMR, 32'hf);
    wr(OFS_CHER, 32'h07);
    wr(OFS_CR, 32'h1 << CR_START);
    wr(OFS_CHDR, 32'h04);
    wait_seq();
    rdc(OFS_CHSR, 32'h03);
    rdc(OFS_SR, 32'h00030003);
    rdc(OFS_SR, 32'h00010003);
    rdc(OFS_ISR, 32'h5);
    chk_irq(1'b1);
    // Channel reads clear one done bit and leave result-ready
    rdc(OFS_CDR0 + 8'h04, 32'h2a5);
    rdc(OFS_SR, 32'h00010001);
    rdc(OFS_CDR0, 32'h123);
    rdc(OFS_SR, 32'h00010000);
    rdc(OFS_LAST_RESULT_REG, 32'h2a5 | (32'h1 << LAST_RESULT_REG_CH_LSB));
    rdc(OFS_SR, 32'h0);
    wr(OFS_ISR, 32'hf);
    rdc(OFS_ISR, 32'h0);
    chk_irq(1'b0);
    // Two runs unread: both channels overrun
    wr(OFS_CR, 32'h1 << CR_START);
    wait_seq();
    wr(OFS_CR, 32'h1 << CR_START);
    wait_seq();
    rdc(OFS_SR, 32'h00030303);
    rdc(OFS_SR, 32'h00010003);
    rdc(OFS_ISR, 32'h7);
    wr(OFS_IMR, 32'h0);
    chk_irq(1'b0);
    wr(OFS_IMR, 32'h1 << EV_OVR);
    chk_irq(1'b1);
    wr(OFS_ISR, 32'h1 << EV_OVR);
    chk_irq(1'b0);
    rdc(OFS_LAST_RESULT_REG, 32'h2a5 | (32'h1 << LAST_RESULT_REG_CH_LSB));
    // Sleep set while idle waits for the next run to finish
    wr(OFS_MR, 32'h1 << MR_SLEEP);
    rdc(OFS_MR, 32'h1);
    repeat (20) @(posedge aclk);
    chk({31'h0, asleep}, 32'h0);
    wr(OFS_CR, 32'h1 << CR_START);
    wait_seq();
    chk({31'h0, asleep}, 32'h1);
    rdc(OFS_SR, 32'h00070003);
    wrap_up();
  end
endmodule : test_adcsf_top
